// file: strap_cfg_pkg.sv
// Purpose: shared constants and types for the strap configuration latch
// Assumes: strap levels are synchronous to core_clk
// Notes:   field positions index the packed strap capture vector
package strap_cfg_pkg;

  // position of each strap in the capture vector
  localparam int unsigned POS_SWITCH_START  = 0;
  localparam int unsigned POS_INBAND_OFF    = 1;
  localparam int unsigned POS_PORT3_ROLE    = 2;
  localparam int unsigned POS_PORT3_SPEED   = 3;
  localparam int unsigned POS_XMII_LO       = 4;
  localparam int unsigned POS_XMII_HI       = 5;
  localparam int unsigned POS_HOST_LO       = 6;
  localparam int unsigned POS_HOST_HI       = 7;
  localparam int unsigned POS_PHY_LO        = 8;
  localparam int unsigned POS_PHY_HI        = 9;
  localparam int unsigned POS_RX_VALID_TEST = 10;
  localparam int unsigned POS_SERIAL_TEST   = 11;
  localparam int unsigned STRAP_W           = 12;

  // default strap levels (pull resistors absent): start on, inband off,
  // mac role, 100M, mii, miim, phy autoneg, normal mode
  localparam logic [11:0] STRAP_RESET = 12'h10f;

  // two-bit strap codes
  localparam logic [1:0] XMII_MII   = 2'h0;
  localparam logic [1:0] XMII_RMII  = 2'h1;
  localparam logic [1:0] XMII_RGMII = 2'h3;
  localparam logic [1:0] HOST_MIIM  = 2'h0;
  localparam logic [1:0] HOST_I2C   = 2'h1;
  localparam logic [1:0] PHY_AN_EEE = 2'h1;
  localparam logic [1:0] PHY_F_MDIX = 2'h2;
  localparam logic [1:0] PHY_F_MDI  = 2'h3;

  typedef enum logic [1:0] {XMII_IS_MII, XMII_IS_RMII, XMII_IS_RSVD, XMII_IS_RGMII} xmii_mode_t;
  typedef enum logic [1:0] {HOST_IS_MIIM, HOST_IS_I2C, HOST_IS_SPI} host_if_t;
  typedef enum logic [1:0] {PHY_IS_RSVD, PHY_IS_AN_EEE, PHY_IS_FORCE_MDIX, PHY_IS_FORCE_MDI}
    phy_mode_t;

endpackage

// file: ptp_gpio_pin.sv
// Purpose: one precision-time gpio pin, capture input or trigger output
// Assumes: ptp_tick marks the 1588 clock edges in the core_clk domain
// Notes:   input level is resynchronised; capture fires on a sampled edge
`timescale 1ns/1ps
module ptp_gpio_pin (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  input  wire logic ptp_tick,
  input  wire logic dir_out,
  input  wire logic drive_level,
  // pin
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  // status
  output logic      sampled_r,
  output logic      capture_pulse
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic out_r;

  // two-stage resync of the pin input
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // sample and drive only on 1588 clock ticks
  always_ff @(posedge clk) begin
    if (reset) begin
      sampled_r <= 1'b0;
      prev_r    <= 1'b0;
      out_r     <= 1'b0;
    end else if (ptp_tick) begin
      sampled_r <= sync2_r;
      prev_r    <= sampled_r;
      out_r     <= drive_level;
    end
  end

  // capture event is any change seen between ticks while an input
  assign capture_pulse = ptp_tick && !dir_out && (sampled_r != prev_r);
  assign pin_out       = out_r;
  assign pin_oe        = dir_out;

  gpio_hold_a: assert property (@(posedge clk) disable iff (reset)
    !ptp_tick |=> $stable(out_r)) else $error("gpio output moved off tick");

endmodule // ptp_gpio_pin

// file: strap_config_latch.sv
// Purpose: capture strap levels at reset release and decode start-up configuration
// Assumes: reset is the synchronous core reset; reset_in_low is the system reset pin
// Notes:   the capture vector is frozen between latch events
// Functional notes
// - sample straps at power-up or software reset end
// - also latch on system reset rising edge
// - start strap low waits for start bit
// - strap low enables inband management
// - port3 role picks phy/mac, refclk direction, status
// - speed strap low gives 1000, high 100
// - xmii strap decodes mii, rmii, reserved, rgmii
// - host strap decodes miim, i2c, spi
// - interrupt pin only pulls low
// - wake output on energy detect, programmable polarity
// - two gpios synced to 1588 clock
// - phy strap decodes autoneg or forced modes
// - test straps high select factory test
`timescale 1ns/1ps
module strap_config_latch (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // reset and power-down sources
  input  wire logic                  reset_in_low,
  input  wire logic                  soft_reset,
  input  wire logic                  power_down,
  // strap pins
  input  wire logic                  strap_switch_start,
  input  wire logic                  strap_inband_mgmt_off,
  input  wire logic                  strap_port3_role,
  input  wire logic                  strap_port3_speed,
  input  wire logic                  strap_xmii_type_hi,
  input  wire logic                  strap_xmii_type_lo,
  input  wire logic                  strap_host_if_hi,
  input  wire logic                  strap_host_if_lo,
  input  wire logic                  strap_phy_cfg_hi,
  input  wire logic                  strap_rx_valid_test,
  input  wire logic                  strap_serial_out_test,
  // wake pin doubles as phy strap low bit
  input  wire logic                  wake_event_in,
  output logic                       wake_event_out,
  output logic                       wake_event_oe,
  // software controls
  input  wire logic                  start_switch_bit,
  input  wire logic                  wake_active_high,
  input  wire logic                  energy_detect,
  input  wire logic                  irq_request,
  // interrupt pin
  output logic                       irq_out_low,
  output logic                       irq_oe,
  // decoded configuration
  output logic                       forward_enable,
  output logic                       inband_management,
  output logic                       port3_phy_mode,
  output logic                       rmii_ref_clock_out,
  output logic                       rmii_ref_clock_in,
  output logic                       inband_link_status,
  output logic                       port3_gigabit,
  output strap_cfg_pkg::xmii_mode_t  xmii_mode,
  output strap_cfg_pkg::host_if_t    host_if,
  output strap_cfg_pkg::phy_mode_t   phy_mode,
  output logic                       factory_test,
  output logic                       strap_latched,
  // precision-time gpios
  input  wire logic                  ptp_tick,
  input  wire logic [1:0]            gpio_dir_out,
  input  wire logic [1:0]            gpio_drive,
  input  wire logic [1:0]            gpio_in,
  output logic      [1:0]            gpio_out,
  output logic      [1:0]            gpio_oe,
  output logic      [1:0]            gpio_sampled,
  output logic      [1:0]            gpio_capture
);

  logic [strap_cfg_pkg::STRAP_W-1:0] strap_r;
  logic [strap_cfg_pkg::STRAP_W-1:0] strap_now;
  logic                              rst_pin_r;
  logic                              pd_r;
  logic                              soft_r;
  logic                              latch_evt;
  logic                              wake_r;
  logic                              start_seen_r;

  // decode two-bit xmii strap
  function automatic strap_cfg_pkg::xmii_mode_t dec_xmii(input logic [1:0] c);
    unique case (c)
      strap_cfg_pkg::XMII_MII:   dec_xmii = strap_cfg_pkg::XMII_IS_MII;
      strap_cfg_pkg::XMII_RMII:  dec_xmii = strap_cfg_pkg::XMII_IS_RMII;
      strap_cfg_pkg::XMII_RGMII: dec_xmii = strap_cfg_pkg::XMII_IS_RGMII;
      default:                   dec_xmii = strap_cfg_pkg::XMII_IS_RSVD;
    endcase
  endfunction

  // decode two-bit host interface strap; upper bit wins
  function automatic strap_cfg_pkg::host_if_t dec_host(input logic [1:0] c);
    if (c[1])
      dec_host = strap_cfg_pkg::HOST_IS_SPI;
    else if (c == strap_cfg_pkg::HOST_I2C)
      dec_host = strap_cfg_pkg::HOST_IS_I2C;
    else
      dec_host = strap_cfg_pkg::HOST_IS_MIIM;
  endfunction

  // decode two-bit phy-port strap
  function automatic strap_cfg_pkg::phy_mode_t dec_phy(input logic [1:0] c);
    unique case (c)
      strap_cfg_pkg::PHY_AN_EEE: dec_phy = strap_cfg_pkg::PHY_IS_AN_EEE;
      strap_cfg_pkg::PHY_F_MDIX: dec_phy = strap_cfg_pkg::PHY_IS_FORCE_MDIX;
      strap_cfg_pkg::PHY_F_MDI:  dec_phy = strap_cfg_pkg::PHY_IS_FORCE_MDI;
      default:                   dec_phy = strap_cfg_pkg::PHY_IS_RSVD;
    endcase
  endfunction

  // gather the live strap levels
  assign strap_now = {strap_serial_out_test, strap_rx_valid_test,
                      strap_phy_cfg_hi, wake_event_in,
                      strap_host_if_hi, strap_host_if_lo,
                      strap_xmii_type_hi, strap_xmii_type_lo,
                      strap_port3_speed, strap_port3_role,
                      strap_inband_mgmt_off, strap_switch_start};

  // history of the reset sources for edge detection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rst_pin_r <= 1'b1;                                // pin idles high: no false rise
      pd_r      <= 1'b0;
      soft_r    <= 1'b0;
    end else begin
      rst_pin_r <= reset_in_low;
      pd_r      <= power_down;
      soft_r    <= soft_reset;
    end
  end

  // latch on end of soft reset, end of power-down or pin reset rising edge
  assign latch_evt = (soft_r && !soft_reset)
                   || (pd_r && !power_down)
                   || (!rst_pin_r && reset_in_low);

  // strap capture register, frozen outside latch events
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_r       <= strap_cfg_pkg::STRAP_RESET;
      strap_latched <= 1'b0;
    end else if (latch_evt) begin
      strap_r       <= strap_now;
      strap_latched <= 1'b1;
    end
  end

  // remember a software start request
  always_ff @(posedge core_clk) begin
    if (reset || latch_evt)
      start_seen_r <= 1'b0;
    else if (start_switch_bit)
      start_seen_r <= 1'b1;
  end

  // decoded configuration
  assign forward_enable     = strap_r[strap_cfg_pkg::POS_SWITCH_START] || start_seen_r;
  assign inband_management  = !strap_r[strap_cfg_pkg::POS_INBAND_OFF];
  assign port3_phy_mode     = !strap_r[strap_cfg_pkg::POS_PORT3_ROLE];
  assign rmii_ref_clock_out = !strap_r[strap_cfg_pkg::POS_PORT3_ROLE];
  assign rmii_ref_clock_in  = strap_r[strap_cfg_pkg::POS_PORT3_ROLE];
  assign inband_link_status = strap_r[strap_cfg_pkg::POS_PORT3_ROLE];
  assign port3_gigabit      = !strap_r[strap_cfg_pkg::POS_PORT3_SPEED];
  assign xmii_mode  = dec_xmii(strap_r[strap_cfg_pkg::POS_XMII_HI:strap_cfg_pkg::POS_XMII_LO]);
  assign host_if    = dec_host(strap_r[strap_cfg_pkg::POS_HOST_HI:strap_cfg_pkg::POS_HOST_LO]);
  assign phy_mode   = dec_phy(strap_r[strap_cfg_pkg::POS_PHY_HI:strap_cfg_pkg::POS_PHY_LO]);
  assign factory_test = strap_r[strap_cfg_pkg::POS_RX_VALID_TEST]
                     || strap_r[strap_cfg_pkg::POS_SERIAL_TEST];

  // open-drain interrupt: drive low only when asserted
  assign irq_out_low = 1'b0;
  assign irq_oe      = irq_request;

  // wake output with programmable polarity, pin released only until the first strap latch
  always_ff @(posedge core_clk) begin
    if (reset)
      wake_r <= 1'b0;
    else
      wake_r <= energy_detect;
  end
  assign wake_event_out = wake_active_high ? wake_r : !wake_r;
  assign wake_event_oe  = strap_latched;

  // precision-time gpio pins
  for (genvar g = 0; g < 2; g++) begin : g_gpio
    ptp_gpio_pin u_pin (
      .clk           (core_clk),
      .reset         (reset),
      .ptp_tick      (ptp_tick),
      .dir_out       (gpio_dir_out[g]),
      .drive_level   (gpio_drive[g]),
      .pin_in        (gpio_in[g]),
      .pin_out       (gpio_out[g]),
      .pin_oe        (gpio_oe[g]),
      .sampled_r     (gpio_sampled[g]),
      .capture_pulse (gpio_capture[g])
    );
  end

  // assertions
  sequence s_pin_rise;
    !reset_in_low ##1 reset_in_low;
  endsequence

  strap_pin_latch_a: assert property (@(posedge core_clk) disable iff (reset)
    s_pin_rise |=> strap_r == $past(strap_now)) else $error("strap not latched on reset rise");
  strap_soft_latch_a: assert property (@(posedge core_clk) disable iff (reset)
    soft_r && !soft_reset |=> strap_r == $past(strap_now)) else $error("strap not latched");
  strap_frozen_a: assert property (@(posedge core_clk) disable iff (reset)
    !latch_evt |=> $stable(strap_r)) else $error("strap changed between latches");
  forward_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !strap_r[0] && !start_seen_r |-> !forward_enable) else $error("forwarding without start");
  inband_dec_a: assert property (@(posedge core_clk) disable iff (reset)
    inband_management == !strap_r[1]) else $error("inband decode wrong");
  role_dec_a: assert property (@(posedge core_clk) disable iff (reset)
    rmii_ref_clock_in == strap_r[2] && inband_link_status == strap_r[2]
    && rmii_ref_clock_out == !strap_r[2] && port3_phy_mode == !strap_r[2])
    else $error("role decode wrong");
  speed_dec_a: assert property (@(posedge core_clk) disable iff (reset)
    port3_gigabit == !strap_r[3]) else $error("speed decode wrong");
  host_spi_a: assert property (@(posedge core_clk) disable iff (reset)
    strap_r[7] |-> host_if == strap_cfg_pkg::HOST_IS_SPI) else $error("spi decode wrong");
  xmii_rgmii_a: assert property (@(posedge core_clk) disable iff (reset)
    strap_r[5:4] == 2'h3 |-> xmii_mode == strap_cfg_pkg::XMII_IS_RGMII)
    else $error("rgmii decode wrong");
  phy_mdi_a: assert property (@(posedge core_clk) disable iff (reset)
    strap_r[9:8] == 2'h3 |-> phy_mode == strap_cfg_pkg::PHY_IS_FORCE_MDI)
    else $error("phy decode wrong");
  irq_drive_a: assert property (@(posedge core_clk) disable iff (reset)
    irq_oe |-> !irq_out_low) else $error("irq drives high");
  wake_pol_a: assert property (@(posedge core_clk) disable iff (reset)
    energy_detect && wake_active_high ##1 wake_active_high |-> wake_event_out)
    else $error("wake not asserted");

endmodule // strap_config_latch

// file: strap_source.sv
// Purpose: strap resistors and system reset source beside the strap latch
// Assumes: pins are reused as led/data outputs once the strap hold is dropped
// Notes:   released pins toggle every cycle so a stale level never passes
`timescale 1ns/1ps
module strap_source (
  // clock
  input  wire logic        core_clk,
  // control from the bench
  input  wire logic [11:0] pattern,
  input  wire logic        strap_hold,
  input  wire logic        sys_rst_req,
  // pins
  output logic      [11:0] strap_pins,
  output logic             reset_in_low
);
  // resistors hold the pattern, otherwise the pins carry led/data traffic
  always_ff @(posedge core_clk) begin
    if (strap_hold) begin
      strap_pins <= pattern;
    end else begin
      strap_pins <= ~strap_pins;
    end
  end
  // reset source pulls the system reset pin low on request
  always_ff @(posedge core_clk) begin
    reset_in_low <= ~sys_rst_req;
  end
endmodule // strap_source

// file: testbench.sv
// Purpose: self-checking bench for the strap configuration latch
// Assumes: inputs change by non-blocking assignment at the rising edge
// Notes:   outputs are sampled at the falling edge
`timescale 1ns/1ps
module testbench;
  logic core_clk, reset, soft_reset, power_down, strap_hold, sys_rst_req, reset_in_low;
  logic start_switch_bit, wake_active_high, energy_detect, irq_request, ptp_tick;
  logic wake_event_out, wake_event_oe, irq_out_low, irq_oe, forward_enable, inband_management;
  logic port3_phy_mode, rmii_ref_clock_out, rmii_ref_clock_in, inband_link_status;
  logic port3_gigabit, factory_test, strap_latched;
  logic [11:0] pattern, pins;
  logic [1:0] gpio_dir_out, gpio_drive, gpio_in, gpio_out, gpio_oe, gpio_sampled, gpio_capture;
  logic [1:0] cap_seen = 2'h0;
  strap_cfg_pkg::xmii_mode_t xmii_mode;
  strap_cfg_pkg::host_if_t   host_if;
  strap_cfg_pkg::phy_mode_t  phy_mode;
  int mismatches = 0;
  int n_compared = 0;

  // clock generator
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // remember any capture pulse
  always @(posedge core_clk) cap_seen <= cap_seen | gpio_capture;

  strap_source u_src (.core_clk(core_clk), .pattern(pattern), .strap_hold(strap_hold),
    .sys_rst_req(sys_rst_req), .strap_pins(pins), .reset_in_low(reset_in_low));

  strap_config_latch u_dut (.core_clk(core_clk), .reset(reset), .reset_in_low(reset_in_low),
    .soft_reset(soft_reset), .power_down(power_down), .strap_switch_start(pins[0]),
    .strap_inband_mgmt_off(pins[1]), .strap_port3_role(pins[2]), .strap_port3_speed(pins[3]),
    .strap_xmii_type_lo(pins[4]), .strap_xmii_type_hi(pins[5]), .strap_host_if_lo(pins[6]),
    .strap_host_if_hi(pins[7]), .wake_event_in(pins[8]), .strap_phy_cfg_hi(pins[9]),
    .strap_rx_valid_test(pins[10]), .strap_serial_out_test(pins[11]),
    .wake_event_out(wake_event_out), .wake_event_oe(wake_event_oe),
    .start_switch_bit(start_switch_bit), .wake_active_high(wake_active_high),
    .energy_detect(energy_detect), .irq_request(irq_request), .irq_out_low(irq_out_low),
    .irq_oe(irq_oe), .forward_enable(forward_enable), .inband_management(inband_management),
    .port3_phy_mode(port3_phy_mode), .rmii_ref_clock_out(rmii_ref_clock_out),
    .rmii_ref_clock_in(rmii_ref_clock_in), .inband_link_status(inband_link_status),
    .port3_gigabit(port3_gigabit), .xmii_mode(xmii_mode), .host_if(host_if),
    .phy_mode(phy_mode), .factory_test(factory_test), .strap_latched(strap_latched),
    .ptp_tick(ptp_tick), .gpio_dir_out(gpio_dir_out), .gpio_drive(gpio_drive),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_sampled(gpio_sampled), .gpio_capture(gpio_capture));

  // one comparison
  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // latch a pattern through one source: 0 reset pin, 1 soft reset, 2 power-down
  task automatic latch(input int s, input logic [11:0] p);
    @(posedge core_clk);
    pattern <= p;
    strap_hold <= 1'b1;
    @(posedge core_clk);
    case (s)
      0: sys_rst_req <= 1'b1;
      1: soft_reset <= 1'b1;
      default: power_down <= 1'b1;
    endcase
    repeat (2) @(posedge core_clk);
    sys_rst_req <= 1'b0;
    soft_reset <= 1'b0;
    power_down <= 1'b0;
    repeat (3) @(posedge core_clk);
    strap_hold <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // compare every decoded output with the pattern
  task automatic check_cfg(input logic [11:0] p, input logic lat);
    @(negedge core_clk);
    chk("strap_latched", lat, strap_latched);
    chk("forward_enable", p[0], forward_enable);
    chk("inband_management", !p[1], inband_management);
    chk("port3_phy_mode", !p[2], port3_phy_mode);
    chk("rmii_ref_clock_out", !p[2], rmii_ref_clock_out);
    chk("rmii_ref_clock_in", p[2], rmii_ref_clock_in);
    chk("inband_link_status", p[2], inband_link_status);
    chk("port3_gigabit", !p[3], port3_gigabit);
    chk("xmii_mode", p[5:4], xmii_mode);
    chk("host_if", p[7] ? 2'h2 : p[7:6], host_if);
    chk("phy_mode", p[9:8], phy_mode);
    chk("factory_test", p[10] | p[11], factory_test);
  endtask

  // start strap low waits for the start bit, a new latch clears it
  task automatic t_start();
    latch(1, 12'h00e);
    check_cfg(12'h00e, 1'b1);
    @(posedge core_clk) start_switch_bit <= 1'b1;
    @(posedge core_clk) start_switch_bit <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("forward_enable", 1'b1, forward_enable);
    latch(2, 12'h00e);
    check_cfg(12'h00e, 1'b1);
  endtask

  // interrupt pull-down and wake polarity
  task automatic t_pins();
    @(posedge core_clk);
    irq_request <= 1'b1;
    energy_detect <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("irq_oe", 1'b1, irq_oe);
    chk("irq_out_low", 1'b0, irq_out_low);
    chk("wake_event_out", 1'b1, wake_event_out);
    chk("wake_event_oe", 1'b1, wake_event_oe);
    @(posedge core_clk);
    irq_request <= 1'b0;
    wake_active_high <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("irq_oe", 1'b0, irq_oe);
    chk("wake_event_out", 1'b0, wake_event_out);
    @(posedge core_clk) energy_detect <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("wake_event_out", 1'b1, wake_event_out);
  endtask

  // gpio drive on a tick, then capture of an input change
  task automatic t_gpio();
    @(posedge core_clk);
    gpio_dir_out <= 2'h3;
    gpio_drive <= 2'h1;
    ptp_tick <= 1'b1;
    @(posedge core_clk) ptp_tick <= 1'b0;
    @(negedge core_clk);
    chk("gpio_out", 2'h1, gpio_out);
    chk("gpio_oe", 2'h3, gpio_oe);
    @(posedge core_clk);
    gpio_dir_out <= 2'h0;
    gpio_in <= 2'h2;
    repeat (4) begin
      repeat (3) @(posedge core_clk);
      ptp_tick <= 1'b1;
      @(posedge core_clk) ptp_tick <= 1'b0;
    end
    @(negedge core_clk);
    chk("gpio_sampled", 2'h2, gpio_sampled);
    chk("gpio_capture", 2'h2, cap_seen);
    chk("gpio_oe", 2'h0, gpio_oe);
  endtask

  // watchdog
  initial begin
    #(100 * 5000);
    mismatches++;
    finish_test();
  end

  // main sequence
  initial begin
    logic [11:0] p;
    logic [1:0] c;
    reset = 1'b1;
    {soft_reset, power_down, sys_rst_req, start_switch_bit, energy_detect} = 5'h00;
    {irq_request, ptp_tick, gpio_dir_out, gpio_drive, gpio_in} = 8'h00;
    wake_active_high = 1'b1;
    pattern = strap_cfg_pkg::STRAP_RESET;
    strap_hold = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // let two edges pass with the pin idle high: nothing may latch
    repeat (2) @(posedge core_clk);
    check_cfg(strap_cfg_pkg::STRAP_RESET, 1'b0);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      p = {c == 2'h3, c == 2'h2, c, c, c, ~(c[0] & c[1]), c[1], ~c[1], c[0]};
      latch(i % 3, p);
      check_cfg(p, 1'b1);
    end
    t_start();
    t_pins();
    t_gpio();
    finish_test();
  end
endmodule // testbench
